// ---- hw/overlay_pkg.sv ----
// Constants, map type and overlay decode shared by the overlay memory block
package overlay_pkg;
	localparam int PM_WORDS = 32768;
	localparam int DM_WORDS = 32768;
	localparam int PHYS_W = 15;
	localparam int PM_WIDTH = 24;
	localparam int DM_WIDTH = 16;
	localparam logic [13:0] WINDOW_BASE = 14'h2000;
	localparam logic [3:0] OVL_INT_A = 4'h0;
	localparam logic [3:0] OVL_EXT_1 = 4'h1;
	localparam logic [3:0] OVL_EXT_2 = 4'h2;
	localparam logic [3:0] OVL_INT_B = 4'h4;
	localparam logic [3:0] OVL_INT_C = 4'h5;
	localparam int HOST_CTRL_OVL_BIT = 15;
	localparam int HOST_CTRL_PM_BIT = 14;
	localparam int HOST_OVL_PM_LSB = 0;
	localparam int HOST_OVL_DM_LSB = 4;
	localparam logic [15:0] HOST_OVL_RESET = 16'h0000;
	localparam logic [13:0] BYTE_INT_ADDR_OFS = 14'h3fe1;
	localparam logic [13:0] BYTE_EXT_ADDR_OFS = 14'h3fe2;
	localparam logic [13:0] BYTE_CTRL_OFS = 14'h3fe3;
	localparam logic [13:0] BYTE_COUNT_OFS = 14'h3fe4;
	localparam int BYTE_TYPE_LSB = 0;
	localparam int BYTE_OVL_LSB = 4;
	localparam int BYTE_PAGE_LSB = 8;
	localparam logic [15:0] BYTE_REG_RESET = 16'h0000;
	localparam logic [1:0] BYTE_TYPE_PM24 = 2'h0;
	localparam logic [1:0] BYTE_TYPE_DM16 = 2'h1;
	localparam logic [1:0] BYTE_TYPE_DM8_HI = 2'h2;
	localparam int BYTE_ADDR_W = 19;
	localparam int CLK_PERIOD_NS = 40;
	localparam int BYTE_ACCESS_NS = 160;
	localparam logic [3:0] BYTE_WAIT_CYCLES = 4'((BYTE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [13:0] EXT_OE_HOST_N = 14'h3ffe;
	localparam logic [13:0] EXT_OE_FULL_N = 14'h0000;

	typedef struct packed {
		logic internal;
		logic external;
		logic bank;
		logic [PHYS_W-1:0] phys;
	} overlay_map_s;

	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_WAIT = 2'b01,
		B_STORE = 2'b10
	} byte_state_e;

	// Reserved select codes yield neither internal nor external access
	function automatic overlay_map_s map_overlay(input logic [13:0] addr, input logic [3:0] sel);
		overlay_map_s m;
		m = '0;
		if (addr < WINDOW_BASE) begin
			m.internal = 1'b1;
			m.phys = {2'b00, addr[12:0]};
		end else if (sel == OVL_INT_A) begin
			m.internal = 1'b1;
			m.phys = {2'b01, addr[12:0]};
		end else if (sel == OVL_INT_B) begin
			m.internal = 1'b1;
			m.phys = {2'b10, addr[12:0]};
		end else if (sel == OVL_INT_C) begin
			m.internal = 1'b1;
			m.phys = {2'b11, addr[12:0]};
		end else if (sel == OVL_EXT_1 || sel == OVL_EXT_2) begin
			m.external = 1'b1;
			m.bank = (sel == OVL_EXT_2);
			m.phys = {2'b00, addr[12:0]};
		end
		return m;
	endfunction : map_overlay
endpackage : overlay_pkg

// ---- hw/overlay_ram.sv ----
// Single-port synchronous RAM for one internal memory space
`timescale 1ns/1ps
module overlay_ram #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32768,
	parameter int ADDR_W = 15
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic en,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_next;

	always_comb begin
		rd_data_next = rd_data;
		if (en && !wr_en) begin
			rd_data_next = mem[addr];
		end
	end

	// Array kept out of reset so it maps onto block RAM
	always_ff @(posedge ref_clk) begin
		if (en && wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= rd_data_next;
		end
	end
endmodule : overlay_ram

// ---- hw/memory_overlay_dma_access.sv ----
// Overlay-mapped program and data memory with host-side and byte DMA access
// Overview of operation
// (R1) Two separate 32K-word spaces: program memory and data memory.
// (R2) Program memory: one fixed 8K segment plus three 8K overlays by program select.
// (R3) Data memory likewise by data select; two external 8K overlays per space.
// (R4) Codes 0,4,5 internal; 1 drives bank bit low, 2 high, low 13 bits out.
// (R5) Host port and byte DMA each reach overlays through their own overlay field.
// (R6) Host mode exposes only address pin A0 of the external address bus.
// (R7) Host-side DMA port works only in host mode.
// (R8) Host latches overlay page and start address in two separate latch cycles.
// (R9) Latched control word with bit 15 set becomes overlay page information.
// (R10) Bit 15 clear: word is start address, bit 14 picks program or data.
// (R11) Host overlay register stays all zeros until a page is latched.
// (R12) Host should latch the page before addresses run into an overlay.
// (R13) Host control register has no defined reset value.
// (R14) Acknowledge pin is open-drain or always driven per a mode pin; the driven setting here drives it only in host mode.
// (R15) Full memory mode: all address lines out, host port disabled.
// (R16) Byte memory space is external, 8 bits wide, up to 4 Mbits.
// (R17) Byte DMA works only in full memory mode.
// (R18) Byte DMA overlay comes from control bits 7 to 4.
// (R19) Byte DMA registers at data addresses 0x3fe1 to 0x3fe4.
// (R20) Reserved overlay codes give no access at all.
`timescale 1ns/1ps
module memory_overlay_dma_access #(
	parameter int BYTE_ADDR_W = overlay_pkg::BYTE_ADDR_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic mode_host_pin,
	input wire logic ack_open_drain_pin,
	input wire logic core_req,
	input wire logic core_pm,
	input wire logic core_wr,
	input wire logic [13:0] core_addr,
	input wire logic [overlay_pkg::PM_WIDTH-1:0] core_wdata,
	input wire logic [3:0] program_overlay_select,
	input wire logic [3:0] data_overlay_select,
	output logic core_stall,
	output logic [overlay_pkg::PM_WIDTH-1:0] core_rdata,
	output logic [13:0] ext_addr_out,
	output logic [13:0] ext_addr_oe_n,
	output logic ext_strobe,
	output logic ext_wr,
	input wire logic host_latch,
	input wire logic host_write,
	input wire logic host_read,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	input wire logic host_access_acknowledge_in,
	output logic host_access_acknowledge_out,
	output logic host_access_acknowledge_oe_n,
	output logic [BYTE_ADDR_W-1:0] byte_addr,
	output logic byte_rd,
	input wire logic [7:0] byte_rdata
);
	import overlay_pkg::*;

	localparam int PIN_W = 29;
	logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
	logic mode_host, ack_od, latch_edge, write_edge, read_edge;
	logic [15:0] host_data;
	logic [7:0] byte_data;

	// Two-stage synchroniser; edges taken from the second stage only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			pin_prev_reg <= '0;
		end else begin
			pin_meta_reg <= {mode_host_pin, ack_open_drain_pin, host_latch, host_write, host_read,
				host_data_in, byte_rdata};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign mode_host = pin_sync_reg[28];
	assign ack_od = pin_sync_reg[27];
	assign latch_edge = mode_host && pin_sync_reg[26] && !pin_prev_reg[26]; // R7
	assign write_edge = mode_host && pin_sync_reg[25] && !pin_prev_reg[25]; // R7
	assign read_edge = mode_host && pin_sync_reg[24] && !pin_prev_reg[24]; // R7
	assign host_data = pin_sync_reg[23:8];
	assign byte_data = pin_sync_reg[7:0];

	// Host-side DMA port
	logic [15:0] host_ovl_reg, host_ovl_next;
	logic [13:0] host_addr_reg, host_addr_next;
	logic host_pm_reg, host_pm_next;
	logic [15:0] host_hold_reg, host_hold_next;
	logic host_phase_reg, host_phase_next;
	logic host_pend_reg, host_pend_next;
	logic host_busy_reg, host_busy_next;
	logic [15:0] host_rdata_reg, host_rdata_next;
	logic host_ram_en, host_ram_we;
	logic [PM_WIDTH-1:0] host_ram_wdata;
	overlay_map_s host_map;
	logic [PM_WIDTH-1:0] pm_rd_data;
	logic [DM_WIDTH-1:0] dm_rd_data;

	assign host_map = map_overlay(host_addr_reg, host_pm_reg ?
		host_ovl_reg[HOST_OVL_PM_LSB +: 4] : host_ovl_reg[HOST_OVL_DM_LSB +: 4]); // R5

	always_comb begin
		host_ovl_next = host_ovl_reg;
		host_addr_next = host_addr_reg;
		host_pm_next = host_pm_reg;
		host_hold_next = host_hold_reg;
		host_phase_next = host_phase_reg;
		host_pend_next = 1'b0;
		host_rdata_next = host_rdata_reg;
		host_busy_next = latch_edge || write_edge || read_edge || host_pend_reg;
		host_ram_en = 1'b0;
		host_ram_we = 1'b0;
		host_ram_wdata = {8'h00, host_data};
		if (latch_edge) begin
			if (host_data[HOST_CTRL_OVL_BIT]) begin
				host_ovl_next = host_data; // R9
			end else begin
				host_addr_next = host_data[13:0]; // R10
				host_pm_next = host_data[HOST_CTRL_PM_BIT]; // R10
				host_phase_next = 1'b0;
			end
		end else if (write_edge) begin
			if (host_pm_reg && !host_phase_reg) begin
				host_hold_next = host_data;
				host_phase_next = 1'b1;
			end else begin
				host_ram_en = host_map.internal; // R20
				host_ram_we = host_map.internal;
				host_ram_wdata = host_pm_reg ? {host_hold_reg, host_data[7:0]} : {8'h00, host_data};
				host_addr_next = 14'(host_addr_reg + 14'h0001);
				host_phase_next = 1'b0;
			end
		end else if (read_edge) begin
			if (host_pm_reg && host_phase_reg) begin
				host_rdata_next = {8'h00, host_hold_reg[7:0]};
				host_addr_next = 14'(host_addr_reg + 14'h0001);
				host_phase_next = 1'b0;
			end else begin
				host_ram_en = host_map.internal;
				host_pend_next = 1'b1;
			end
		end else if (host_pend_reg) begin
			if (host_pm_reg) begin
				host_rdata_next = pm_rd_data[23:8];
				host_hold_next = {8'h00, pm_rd_data[7:0]};
				host_phase_next = 1'b1;
			end else begin
				host_rdata_next = dm_rd_data;
				host_addr_next = 14'(host_addr_reg + 14'h0001);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_ovl_reg <= HOST_OVL_RESET; // R11
			host_phase_reg <= 1'b0;
			host_pend_reg <= 1'b0;
			host_busy_reg <= 1'b0;
			host_rdata_reg <= '0;
		end else begin
			host_ovl_reg <= host_ovl_next;
			host_phase_reg <= host_phase_next;
			host_pend_reg <= host_pend_next;
			host_busy_reg <= host_busy_next;
			host_rdata_reg <= host_rdata_next;
		end
	end

	// Left out of reset on purpose: contents undefined until latched
	always_ff @(posedge ref_clk) begin
		host_addr_reg <= host_addr_next; // R13
		host_pm_reg <= host_pm_next;
		host_hold_reg <= host_hold_next;
	end

	assign host_data_out = host_rdata_reg;
	// Open-drain only ever pulls low, so ack is active low on the wire
	assign host_access_acknowledge_out = ack_od ? 1'b0 : !(mode_host && !host_busy_reg); // R14
	assign host_access_acknowledge_oe_n = ack_od ? !(mode_host && !host_busy_reg) : !mode_host; // R14

	// Byte DMA controller
	logic [13:0] byte_int_reg, byte_int_next;
	logic [13:0] byte_ext_reg, byte_ext_next;
	logic [15:0] byte_ctrl_reg, byte_ctrl_next;
	logic [15:0] byte_count_reg, byte_count_next;
	byte_state_e byte_state_reg, byte_state_next;
	logic [3:0] byte_wait_reg, byte_wait_next;
	logic [1:0] byte_left_reg, byte_left_next;
	logic [23:0] byte_asm_reg, byte_asm_next;
	logic byte_rd_reg, byte_rd_next;
	logic [1:0] byte_type;
	logic byte_ram_we, byte_pm;
	logic [PM_WIDTH-1:0] byte_word;
	overlay_map_s byte_map;
	logic core_reg_hit, core_reg_we;

	assign byte_type = byte_ctrl_reg[BYTE_TYPE_LSB +: 2];
	assign byte_pm = (byte_type == BYTE_TYPE_PM24);
	assign byte_map = map_overlay(byte_int_reg, byte_ctrl_reg[BYTE_OVL_LSB +: 4]); // R18
	assign core_reg_hit = core_req && !core_pm && core_addr >= BYTE_INT_ADDR_OFS
		&& core_addr <= BYTE_COUNT_OFS; // R19
	assign core_reg_we = core_reg_hit && core_wr;

	always_comb begin
		byte_int_next = byte_int_reg;
		byte_ext_next = byte_ext_reg;
		byte_ctrl_next = byte_ctrl_reg;
		byte_count_next = byte_count_reg;
		byte_state_next = byte_state_reg;
		byte_wait_next = byte_wait_reg;
		byte_left_next = byte_left_reg;
		byte_asm_next = byte_asm_reg;
		byte_rd_next = byte_rd_reg;
		byte_ram_we = 1'b0;
		if (byte_type == BYTE_TYPE_PM24) begin
			byte_word = byte_asm_reg;
		end else if (byte_type == BYTE_TYPE_DM16) begin
			byte_word = {8'h00, byte_asm_reg[15:0]};
		end else if (byte_type == BYTE_TYPE_DM8_HI) begin
			byte_word = {8'h00, byte_asm_reg[7:0], 8'h00};
		end else begin
			byte_word = {16'h0000, byte_asm_reg[7:0]};
		end
		case (byte_state_reg)
			B_IDLE: begin
				if (!mode_host && byte_count_reg != 16'h0000) begin // R17
					byte_rd_next = 1'b1;
					byte_wait_next = BYTE_WAIT_CYCLES;
					byte_left_next = byte_pm ? 2'd3 : (byte_type == BYTE_TYPE_DM16 ? 2'd2 : 2'd1);
					byte_state_next = B_WAIT;
				end
			end
			B_WAIT: begin
				if (byte_wait_reg != 4'h1) begin
					byte_wait_next = 4'(byte_wait_reg - 4'h1);
				end else begin
					// Most significant byte arrives first
					byte_asm_next = {byte_asm_reg[15:0], byte_data}; // R16
					byte_ext_next = 14'(byte_ext_reg + 14'h0001);
					byte_left_next = 2'(byte_left_reg - 2'd1);
					byte_wait_next = BYTE_WAIT_CYCLES;
					if (byte_left_reg == 2'd1) begin
						byte_rd_next = 1'b0;
						byte_state_next = B_STORE;
					end
				end
			end
			B_STORE: begin
				byte_ram_we = byte_map.internal; // R20
				byte_int_next = 14'(byte_int_reg + 14'h0001);
				byte_count_next = 16'(byte_count_reg - 16'h0001);
				byte_state_next = B_IDLE;
			end
			default: begin
				byte_state_next = B_IDLE;
			end
		endcase
		if (core_reg_we) begin
			if (core_addr == BYTE_INT_ADDR_OFS) begin
				byte_int_next = core_wdata[13:0];
			end else if (core_addr == BYTE_EXT_ADDR_OFS) begin
				byte_ext_next = core_wdata[13:0];
			end else if (core_addr == BYTE_CTRL_OFS) begin
				byte_ctrl_next = core_wdata[15:0];
			end else begin
				byte_count_next = core_wdata[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			byte_int_reg <= BYTE_REG_RESET[13:0];
			byte_ext_reg <= BYTE_REG_RESET[13:0];
			byte_ctrl_reg <= BYTE_REG_RESET;
			byte_count_reg <= BYTE_REG_RESET;
			byte_state_reg <= B_IDLE;
			byte_wait_reg <= 4'h0;
			byte_left_reg <= 2'd0;
			byte_asm_reg <= 24'h000000;
			byte_rd_reg <= 1'b0;
		end else begin
			byte_int_reg <= byte_int_next;
			byte_ext_reg <= byte_ext_next;
			byte_ctrl_reg <= byte_ctrl_next;
			byte_count_reg <= byte_count_next;
			byte_state_reg <= byte_state_next;
			byte_wait_reg <= byte_wait_next;
			byte_left_reg <= byte_left_next;
			byte_asm_reg <= byte_asm_next;
			byte_rd_reg <= byte_rd_next;
		end
	end

	assign byte_addr = BYTE_ADDR_W'({byte_ctrl_reg[BYTE_PAGE_LSB +: 8], byte_ext_reg});
	assign byte_rd = byte_rd_reg;

	// Memory ports: DMA wins over the core, which stalls instead
	overlay_map_s core_map;
	logic pm_dma, dm_dma, core_go;
	logic pm_en, pm_we, dm_en, dm_we;
	logic [PHYS_W-1:0] pm_addr, dm_addr;
	logic [PM_WIDTH-1:0] pm_wdata;
	logic [DM_WIDTH-1:0] dm_wdata;
	logic [13:0] ext_addr_reg, ext_addr_next;
	logic ext_strobe_reg, ext_strobe_next, ext_wr_reg, ext_wr_next;
	logic [1:0] rsel_reg, rsel_next;
	logic [15:0] core_reg_rdata_reg, core_reg_rdata_next;

	assign core_map = map_overlay(core_addr, core_pm ? program_overlay_select : data_overlay_select); // R2 R3
	assign pm_dma = (host_ram_en && host_pm_reg) || (byte_ram_we && byte_pm);
	assign dm_dma = (host_ram_en && !host_pm_reg) || (byte_ram_we && !byte_pm);
	assign core_stall = core_req && (core_pm ? pm_dma : dm_dma);
	assign core_go = core_req && !core_stall && !core_reg_hit;

	always_comb begin
		pm_en = core_go && core_pm && core_map.internal;
		pm_we = core_wr;
		pm_addr = core_map.phys;
		pm_wdata = core_wdata;
		dm_en = core_go && !core_pm && core_map.internal;
		dm_we = core_wr;
		dm_addr = core_map.phys;
		dm_wdata = core_wdata[15:0];
		if (host_ram_en) begin
			pm_en = host_pm_reg || pm_en;
			dm_en = !host_pm_reg || dm_en;
			if (host_pm_reg) begin
				pm_we = host_ram_we;
				pm_addr = host_map.phys;
				pm_wdata = host_ram_wdata;
			end else begin
				dm_we = host_ram_we;
				dm_addr = host_map.phys;
				dm_wdata = host_ram_wdata[15:0];
			end
		end else if (byte_ram_we) begin
			if (byte_pm) begin
				pm_en = 1'b1;
				pm_we = 1'b1;
				pm_addr = byte_map.phys;
				pm_wdata = byte_word;
			end else begin
				dm_en = 1'b1;
				dm_we = 1'b1;
				dm_addr = byte_map.phys;
				dm_wdata = byte_word[15:0];
			end
		end
		ext_addr_next = ext_addr_reg;
		ext_strobe_next = core_go && core_map.external;
		ext_wr_next = core_go && core_map.external && core_wr;
		if (core_go && core_map.external) begin
			ext_addr_next = {core_map.bank, core_map.phys[12:0]}; // R4
		end
		rsel_next = core_pm ? 2'd1 : 2'd0;
		if (core_reg_hit) begin
			rsel_next = 2'd2;
		end
		core_reg_rdata_next = core_reg_rdata_reg;
		if (core_reg_hit && !core_wr) begin
			if (core_addr == BYTE_INT_ADDR_OFS) begin
				core_reg_rdata_next = {2'b00, byte_int_reg};
			end else if (core_addr == BYTE_EXT_ADDR_OFS) begin
				core_reg_rdata_next = {2'b00, byte_ext_reg};
			end else if (core_addr == BYTE_CTRL_OFS) begin
				core_reg_rdata_next = byte_ctrl_reg;
			end else begin
				core_reg_rdata_next = byte_count_reg;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_addr_reg <= 14'h0000;
			ext_strobe_reg <= 1'b0;
			ext_wr_reg <= 1'b0;
			rsel_reg <= 2'd0;
			core_reg_rdata_reg <= 16'h0000;
		end else begin
			ext_addr_reg <= ext_addr_next;
			ext_strobe_reg <= ext_strobe_next;
			ext_wr_reg <= ext_wr_next;
			rsel_reg <= rsel_next;
			core_reg_rdata_reg <= core_reg_rdata_next;
		end
	end

	assign ext_addr_out = ext_addr_reg;
	assign ext_addr_oe_n = mode_host ? EXT_OE_HOST_N : EXT_OE_FULL_N; // R6 R15
	assign ext_strobe = ext_strobe_reg;
	assign ext_wr = ext_wr_reg;
	assign core_rdata = rsel_reg == 2'd2 ? {8'h00, core_reg_rdata_reg} :
		(rsel_reg == 2'd1 ? pm_rd_data : {8'h00, dm_rd_data});

	overlay_ram #(.WIDTH(PM_WIDTH), .DEPTH(PM_WORDS), .ADDR_W(PHYS_W)) u_program_memory ( // R1
		.ref_clk(ref_clk), .rst(rst), .en(pm_en), .wr_en(pm_we), .addr(pm_addr),
		.wr_data(pm_wdata), .rd_data(pm_rd_data));
	overlay_ram #(.WIDTH(DM_WIDTH), .DEPTH(DM_WORDS), .ADDR_W(PHYS_W)) u_data_memory ( // R1
		.ref_clk(ref_clk), .rst(rst), .en(dm_en), .wr_en(dm_we), .addr(dm_addr),
		.wr_data(dm_wdata), .rd_data(dm_rd_data));

	sequence s_page_latch;
		latch_edge && host_data[HOST_CTRL_OVL_BIT];
	endsequence
	sequence s_word_latch;
		latch_edge && !host_data[HOST_CTRL_OVL_BIT];
	endsequence

	a_page_latch_stores: assert property (@(posedge ref_clk) disable iff (rst) // R9
		s_page_latch |=> host_ovl_reg == $past(host_data)) else $error("page not stored");
	a_addr_latch_keeps_page: assert property (@(posedge ref_clk) disable iff (rst) // R10
		s_word_latch |=> host_ovl_reg == $past(host_ovl_reg) && host_pm_reg == $past(host_data[14]))
		else $error("address latch corrupted page or space");
	a_page_zero_unlatched: assert property (@(posedge ref_clk) disable iff (rst) // R11
		!$past(latch_edge) && $past(host_ovl_reg) == 16'h0000 |-> host_ovl_reg == 16'h0000)
		else $error("overlay register moved without latch");
	a_host_port_off: assert property (@(posedge ref_clk) disable iff (rst) // R7
		!mode_host |-> !host_ram_en && !host_busy_next) else $error("host port active in full mode");
	a_byte_dma_off: assert property (@(posedge ref_clk) disable iff (rst) // R17
		mode_host && byte_state_reg == B_IDLE |=> byte_state_reg == B_IDLE) else $error("byte dma started in host mode");
	a_only_a0_host: assert property (@(posedge ref_clk) disable iff (rst) // R6
		mode_host |-> ext_addr_oe_n == 14'h3ffe) else $error("host mode exposes upper address");
	a_bank_bit_code: assert property (@(posedge ref_clk) disable iff (rst) // R4
		core_go && core_addr >= WINDOW_BASE
		&& (core_pm ? program_overlay_select : data_overlay_select) == OVL_EXT_2
		|=> ext_strobe && ext_addr_out[13] && ext_addr_out[12:0] == $past(core_addr[12:0]))
		else $error("external bank bit wrong");
	a_ack_open_drain: assert property (@(posedge ref_clk) disable iff (rst) // R14
		ack_od |-> !host_access_acknowledge_out && host_access_acknowledge_oe_n == !(mode_host && !host_busy_reg))
		else $error("open-drain ack drives high");
	a_byte_word_count: assert property (@(posedge ref_clk) disable iff (rst) // R19
		byte_state_reg == B_STORE && !core_reg_we |=> byte_count_reg == 16'($past(byte_count_reg) - 16'h0001)
		&& byte_state_reg == B_IDLE) else $error("word count not decremented");
endmodule : memory_overlay_dma_access

// ---- testbench/byte_mem_model.sv ----
// Byte-wide external memory model behind the byte DMA port
`timescale 1ns/1ps
module byte_mem_model (
	input wire logic ref_clk,
	input wire logic byte_rd,
	input wire logic [18:0] byte_addr,
	output logic [7:0] byte_rdata
);
	initial byte_rdata = 8'h00;
	// Idle bus toggles so stale data never passes for a fetch
	always @(posedge ref_clk) begin
		if (byte_rd) begin
			byte_rdata <= byte_addr[7:0] ^ 8'h5a;
		end else begin
			byte_rdata <= ~byte_rdata;
		end
	end
endmodule : byte_mem_model

// ---- testbench/memory_overlay_dma_access_test.sv ----
// Self-checking bench for the overlay memory block
`timescale 1ns/1ps
module memory_overlay_dma_access_test;
	import overlay_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic mode_host_pin = 1'b0;
	logic ack_open_drain_pin = 1'b0;
	logic core_req = 1'b0;
	logic core_pm = 1'b0;
	logic core_wr = 1'b0;
	logic [13:0] core_addr = 14'h0000;
	logic [23:0] core_wdata = 24'h000000;
	logic [3:0] program_overlay_select = 4'h0;
	logic [3:0] data_overlay_select = 4'h0;
	logic host_latch = 1'b0;
	logic host_write = 1'b0;
	logic host_read = 1'b0;
	logic [15:0] host_data_in = 16'h0000;
	logic core_stall, ext_strobe, ext_wr, byte_rd, ack_out, ack_oe_n, rd_q = 1'b0;
	logic [23:0] core_rdata;
	logic [13:0] ext_addr_out, ext_addr_oe_n;
	logic [15:0] host_data_out;
	logic [18:0] byte_addr;
	logic [7:0] byte_rdata;
	logic [24:0] exp_q[$];
	logic [24:0] ext_q[$];
	logic [24:0] e_v;
	logic [23:0] d[6];
	logic [3:0] cd[3] = '{OVL_INT_A, OVL_INT_B, OVL_INT_C};
	int n_errors = 0;
	int cmp_count = 0;
	int n;
	wire ack_wire = ack_oe_n ? 1'b1 : ack_out;

	memory_overlay_dma_access dut (.ref_clk, .rst, .mode_host_pin, .ack_open_drain_pin, .core_req, .core_pm,
		.core_wr, .core_addr, .core_wdata, .program_overlay_select, .data_overlay_select, .core_stall,
		.core_rdata, .ext_addr_out, .ext_addr_oe_n, .ext_strobe, .ext_wr, .host_latch, .host_write,
		.host_read, .host_data_in, .host_data_out, .host_access_acknowledge_in(ack_wire),
		.host_access_acknowledge_out(ack_out), .host_access_acknowledge_oe_n(ack_oe_n), .byte_addr,
		.byte_rd, .byte_rdata);
	byte_mem_model mem (.ref_clk, .byte_rd, .byte_addr, .byte_rdata);

	always #20 ref_clk = ~ref_clk;

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic end_sim();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task automatic core(input logic pm, input logic wr, input logic [13:0] a, input logic [23:0] wd,
		input logic [3:0] s);
		@(posedge ref_clk);
		core_req <= 1'b1;
		core_pm <= pm;
		core_wr <= wr;
		core_addr <= a;
		core_wdata <= wd;
		program_overlay_select <= s;
		data_overlay_select <= s;
		@(posedge ref_clk);
		for (int i = 0; core_stall && i < 50; i++) @(posedge ref_clk);
		if (core_stall) begin
			n_errors++;
			end_sim();
		end
		core_req <= 1'b0;
	endtask : core

	task automatic rd(input logic pm, input logic [13:0] a, input logic [3:0] s, input logic [23:0] e);
		exp_q.push_back({pm, e});
		core(pm, 1'b0, a, 24'h000000, s);
	endtask : rd

	// Strobe held past the sync delay, then a gap wider than the minimum spacing
	task automatic host(input logic lat, input logic [15:0] v);
		host_data_in <= v;
		@(posedge ref_clk);
		host_latch <= lat;
		host_write <= !lat;
		repeat (5) @(posedge ref_clk);
		host_latch <= 1'b0;
		host_write <= 1'b0;
		repeat (5) @(posedge ref_clk);
	endtask : host

	// Ack sampled while the port is busy, read data once the strobe is over
	task automatic hrd(input logic [15:0] e);
		@(posedge ref_clk);
		host_read <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk({22'h000000, ack_out, ack_oe_n}, {22'h000000, !ack_open_drain_pin, ack_open_drain_pin});
		@(posedge ref_clk);
		host_read <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk({8'h00, host_data_out}, {8'h00, e});
	endtask : hrd

	always @(posedge ref_clk) begin
		rd_q <= core_req && !core_wr && !core_stall && !rst;
		if (rd_q) begin
			e_v = exp_q.size() > 0 ? exp_q.pop_front() : '1;
			chk(e_v[24] ? core_rdata : {8'h00, core_rdata[15:0]}, e_v[23:0]);
		end
		if (ext_strobe) begin
			e_v = ext_q.size() > 0 ? ext_q.pop_front() : '1;
			chk({9'h000, ext_wr, ext_addr_out}, e_v[23:0]);
		end
	end

	initial begin
		void'($urandom(33972));
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({10'h000, ext_addr_oe_n}, {10'h000, EXT_OE_FULL_N});
		chk({23'h000000, ack_oe_n}, 24'h000001);
		for (int k = 0; k < 6; k++) d[k] = 24'($urandom());
		for (int k = 0; k < 6; k++) core(k < 3, 1'b1, 14'h2000, d[k], cd[k % 3]);
		for (int k = 0; k < 6; k++) rd(k < 3, 14'h2000, cd[k % 3], k < 3 ? d[k] : {8'h00, d[k][15:0]});
		core(1'b0, 1'b1, 14'h0010, d[0], OVL_INT_B);
		host(1'b1, 16'h0010);
		host(1'b0, 16'hdead);
		rd(1'b0, 14'h0010, OVL_INT_C, {8'h00, d[0][15:0]});
		$display("test internal overlays done");
		for (int k = 1; k < 3; k++) begin
			ext_q.push_back({10'h000, 1'b1, k == 2, 13'h0abc});
			core(1'b0, 1'b1, 14'h2abc, d[1], 4'(k));
		end
		core(1'b0, 1'b1, 14'h2000, 24'h00ffff, 4'h3);
		rd(1'b0, 14'h2000, OVL_INT_A, {8'h00, d[3][15:0]});
		$display("test external overlays done");
		// First pass 16-bit data words, second pass 24-bit program words
		for (int t = 0; t < 2; t++) begin
			core(1'b0, 1'b1, BYTE_CTRL_OFS, t == 1 ? 24'h000040 : 24'h000041, OVL_INT_A);
			core(1'b0, 1'b1, BYTE_EXT_ADDR_OFS, 24'h000000, OVL_INT_A);
			core(1'b0, 1'b1, BYTE_INT_ADDR_OFS, 24'h002000, OVL_INT_A);
			rd(1'b0, BYTE_CTRL_OFS, OVL_INT_A, t == 1 ? 24'h000040 : 24'h000041);
			core(1'b0, 1'b1, BYTE_COUNT_OFS, 24'h000001, OVL_INT_A);
			for (int i = 0; i < 20 && !byte_rd; i++) @(posedge ref_clk);
			n = 0;
			for (int i = 0; i < 80 && n < 8; i++) begin
				@(posedge ref_clk);
				n = byte_rd ? 0 : n + 1;
			end
			if (n < 8) begin
				n_errors++;
				end_sim();
			end
			rd(1'b0, BYTE_COUNT_OFS, OVL_INT_A, 24'h000000);
			rd(t == 1, 14'h2000, OVL_INT_B, t == 1 ? 24'h5a5b58 : 24'h005a5b);
		end
		$display("test byte dma done");
		mode_host_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk({10'h000, ext_addr_oe_n}, {10'h000, EXT_OE_HOST_N});
		chk({22'h000000, ack_out, ack_oe_n}, 24'h000000);
		host(1'b1, 16'h2000);
		host(1'b0, d[5][15:0]);
		rd(1'b0, 14'h2000, OVL_INT_A, {8'h00, d[5][15:0]});
		host(1'b1, 16'h8050);
		host(1'b1, 16'h2000);
		host(1'b0, 16'hbeef);
		rd(1'b0, 14'h2000, OVL_INT_C, 24'h00beef);
		rd(1'b0, 14'h2000, OVL_INT_A, {8'h00, d[5][15:0]});
		host(1'b1, 16'h6000);
		host(1'b0, 16'h1234);
		host(1'b0, 16'h0056);
		rd(1'b1, 14'h2000, OVL_INT_A, 24'h123456);
		host(1'b1, 16'h2000);
		hrd(16'hbeef);
		ack_open_drain_pin <= 1'b1;
		host(1'b1, 16'h6000);
		hrd(16'h1234);
		hrd(16'h0056);
		$display("test host port done");
		chk(24'(exp_q.size() + ext_q.size()), 24'h000000);
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		end_sim();
	end
endmodule : memory_overlay_dma_access_test
